// ==== rtl/dea_pkg.sv ====
// Constants, register map and carrier types of the demand and energy block
package dea_pkg;
	// Time base
	localparam int CLK_MHZ = 100;
	localparam int TICK_MS = 1;
	localparam int MS_CYC_DEF = TICK_MS * 1000 * CLK_MHZ;
	localparam int SEC_MS_DEF = 1000;
	localparam int SEC_PER_MIN = 60;
	localparam int RMS_MAX_H_X10 = 25;
	localparam logic [15:0] RMS_PER_MIN = 16'h0001;
	localparam logic [15:0] RMS_PER_MAX = 16'(RMS_MAX_H_X10 * 360);
	localparam logic [7:0] PWR_PER_MIN = 8'h01;
	localparam logic [7:0] PWR_PER_MAX = 8'h3c;
	localparam logic [15:0] LED_MS = 16'h000a;
	// Sizes
	localparam int N_RMS = 8;
	localparam int N_INT = 5;
	localparam int N_SUM = 16;
	localparam int N_PW = N_INT + N_SUM;
	localparam int N_TAR = 16;
	localparam int N_DI = 4;
	localparam int N_SRC = N_INT + N_DI;
	localparam int N_RLY = 2;
	localparam int N_LED = 2;
	localparam int WIN_MAX = 15;
	localparam int EI_KWH_IMP = 0;
	localparam int EI_KVARH_IMP = 2;
	localparam logic [33:0] DI_WT = 34'h000000001;
	// Register regions (addr[11:8]) and indices (addr[7:0])
	localparam logic [3:0] RG_CFG = 4'h0;
	localparam logic [3:0] RG_SCFG = 4'h1;
	localparam logic [3:0] RG_RBLK = 4'h2;
	localparam logic [3:0] RG_RMAX = 4'h3;
	localparam logic [3:0] RG_RTS = 4'h4;
	localparam logic [3:0] RG_PBLK = 4'h5;
	localparam logic [3:0] RG_PSLD = 4'h6;
	localparam logic [3:0] RG_PACC = 4'h7;
	localparam logic [3:0] RG_PPRD = 4'h8;
	localparam logic [3:0] RG_PMAX = 4'h9;
	localparam logic [3:0] RG_PTS = 4'ha;
	localparam logic [3:0] RG_ECNT = 4'hb;
	localparam logic [3:0] RG_TEN = 4'hc;
	localparam logic [3:0] RG_TMAX = 4'hd;
	localparam logic [3:0] RG_TTS = 4'he;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_RMS_PER = 8'h01;
	localparam logic [7:0] REG_PWR_PER = 8'h02;
	localparam logic [7:0] REG_WIN = 8'h03;
	localparam logic [7:0] REG_ROLL = 8'h04;
	localparam logic [7:0] REG_LED_K = 8'h05;
	localparam logic [7:0] REG_RLY_RATE = 8'h06;
	localparam logic [7:0] REG_RLY_CFG = 8'h07;
	localparam logic [7:0] REG_TARIFF = 8'h08;
	localparam logic [7:0] REG_SECS = 8'h09;
	// Field positions
	localparam int CTRL_TEST = 0;
	localparam int CTRL_CORR = 1;
	localparam int CTRL_MDRST = 2;
	localparam int SC_ADD = 0;
	localparam int SC_SUB = 9;
	localparam int SC_LEN = 18;
	localparam int SC_LSUB = 19;
	localparam int SC_LIX = 20;
	localparam int RC_KYZ = 16;
	localparam int RC_POL = 18;
	localparam int RC_SRC = 20;
	// Reset values
	localparam logic [15:0] RMS_PER_RST = 16'h0384;
	localparam logic [7:0] PWR_PER_RST = 8'h0f;
	localparam logic [3:0] WIN_RST = 4'h1;
	localparam logic [31:0] ROLL_RST = 32'h3b9aca00;
	localparam logic [31:0] LED_K_RST = 32'h00000064;
	localparam logic [31:0] RLY_RATE_RST = 32'h000003e8;
	localparam logic [31:0] RLY_CFG_RST = 32'h00000064;
	typedef struct packed {
		logic vld;
		logic [N_RMS-1:0][31:0] val;
	} dea_rms_t;
	typedef struct packed {
		logic vld;
		logic [N_INT-1:0][15:0] inc;
	} dea_egy_t;
endpackage

// ==== rtl/dea_top.sv ====
// Demand, energy, pulse and tariff accumulation for the metering unit
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module dea_top #(
	parameter int MS_CYC = dea_pkg::MS_CYC_DEF,
	parameter int SEC_MS = dea_pkg::SEC_MS_DEF
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [11:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire dea_pkg::dea_rms_t i_rms,
	input wire dea_pkg::dea_egy_t i_egy_raw,
	input wire dea_pkg::dea_egy_t i_egy_cor,
	input wire logic [dea_pkg::N_DI-1:0] i_di,
	output logic [dea_pkg::N_RLY-1:0] o_relay,
	output logic [dea_pkg::N_LED-1:0] o_led,
	output logic o_setpt_en,
	output logic o_evrec_en,
	output logic o_corr_en
);
	import dea_pkg::*;

	typedef struct packed {
		logic test;
		logic corr;
		logic [15:0] rms_per;
		logic [7:0] pwr_per;
		logic [3:0] win;
		logic [31:0] roll, led_k, rly_rate, rly_cfg;
		logic [3:0] tariff;
		logic [N_SUM-1:0][23:0] scfg;
		logic [31:0] ms_div, secs;
		logic [15:0] ms_cnt, rsec, psec, rcnt;
		logic seq_on, seq_pe, seq_re;
		logic [4:0] seq_j;
		logic [3:0] wp;
		logic [N_RMS-1:0][47:0] rsum;
		logic [N_RMS-1:0][31:0] rblk, rmax, rts;
		logic [N_PW-1:0][31:0] pe, ps, pl, pblk, pslid, pacc, ppred, pmax, pts, cnt;
		logic [N_PW-1:0][WIN_MAX-1:0][31:0] pwin;
		logic [N_SUM-1:0][N_TAR-1:0][31:0] ten, tmax, tts;
		logic [N_DI-1:0] d1, d2, d3, dl;
		logic [N_RLY-1:0][31:0] racc;
		logic [N_RLY-1:0][15:0] rtm;
		logic [N_RLY-1:0] rtog, rly;
		logic [N_LED-1:0][31:0] lacc;
		logic [N_LED-1:0][15:0] ltm;
		logic [N_LED-1:0] led;
		logic setpt_en, evrec_en, corr_en;
		logic [31:0] rdata;
	} dea_st_t;

	dea_st_t s, n;
	logic md_cmd;

	assign md_cmd = i_wr && i_addr == {RG_CFG, REG_CTRL} && i_wdata[CTRL_MDRST];

	function automatic logic [31:0] div_w(input logic [47:0] num, input logic [15:0] den);
		div_w = (den == 16'h0000) ? 32'h0 : 32'(num / {32'h0, den});
	endfunction

	// Sum of the cnt most recent window entries before slot wp
	function automatic logic [35:0] hist(input logic [WIN_MAX-1:0][31:0] row,
			input logic [3:0] wp, input logic [3:0] cnt);
		logic [35:0] acc;
		int ix;
		acc = '0;
		for (int k = 1; k < WIN_MAX; k++) begin
			ix = (int'(wp) + WIN_MAX - k) % WIN_MAX;
			if (k <= int'(cnt)) acc = acc + 36'(row[ix]);
		end
		hist = acc;
	endfunction

	function automatic logic [31:0] wrapc(input logic [31:0] c, input logic signed [33:0] d,
			input logic [31:0] roll);
		logic signed [35:0] t;
		logic signed [35:0] r;
		r = $signed({4'h0, roll});
		t = $signed({4'h0, c}) + 36'(d);
		if (t >= r) t = t - r;
		else if (t < 0) t = t + r;
		wrapc = t[31:0];
	endfunction

	function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
			input logic [15:0] hi);
		clamp16 = (v < lo) ? lo : (v > hi) ? hi : v;
	endfunction

	always_comb begin
		logic signed [33:0] src [N_SRC];
		logic signed [33:0] sinc [N_SUM];
		logic signed [33:0] ci [N_PW];
		logic [N_DI-1:0] dedge;
		logic ms_tick, sec_tick, corr_act, ovr;
		logic [15:0] pp, rem, t16;
		logic [31:0] ev, lv, bv, sl, pb, ri;
		logic [35:0] hs;
		logic [7:0] ix;
		int j, li;
		src = '{default: '0};
		sinc = '{default: '0};
		ci = '{default: '0};
		dedge = '0;
		ms_tick = 1'b0;
		sec_tick = 1'b0;
		corr_act = 1'b0;
		ovr = 1'b0;
		pp = '0;
		rem = '0;
		t16 = '0;
		ev = '0;
		lv = '0;
		bv = '0;
		sl = '0;
		pb = '0;
		ri = '0;
		hs = '0;
		ix = i_addr[7:0];
		j = int'(s.seq_j);
		li = 0;
		n = s;

		// Pulse inputs: three stages, accepted when the last two agree
		n.d1 = i_di;
		n.d2 = s.d1;
		n.d3 = s.d2;
		for (int i = 0; i < N_DI; i++) begin
			if (s.d2[i] == s.d3[i]) n.dl[i] = s.d3[i];
		end
		dedge = n.dl & ~s.dl;

		// Configuration writes
		if (i_wr && i_addr[11:8] == RG_CFG) begin
			unique case (ix)
				REG_CTRL: begin
					n.test = i_wdata[CTRL_TEST];
					n.corr = i_wdata[CTRL_CORR];
				end
				REG_RMS_PER: n.rms_per = clamp16(i_wdata[15:0], RMS_PER_MIN, RMS_PER_MAX);
				REG_PWR_PER: n.pwr_per = 8'(clamp16(i_wdata[15:0], 16'(PWR_PER_MIN),
					16'(PWR_PER_MAX)));
				REG_WIN: n.win = 4'(clamp16(i_wdata[15:0], 16'h0001, 16'(WIN_MAX)));
				REG_ROLL: n.roll = (i_wdata == 32'h0) ? 32'h1 : i_wdata;
				REG_LED_K: n.led_k = i_wdata;
				REG_RLY_RATE: n.rly_rate = i_wdata;
				REG_RLY_CFG: n.rly_cfg = i_wdata;
				REG_TARIFF: n.tariff = i_wdata[3:0];
				default: ;
			endcase
		end
		if (i_wr && i_addr[11:8] == RG_SCFG && ix < 8'(N_SUM)) n.scfg[ix[3:0]] = i_wdata[23:0];

		// Metered energy: corrected when correction is on, else raw; nothing in test
		corr_act = s.corr && !s.test;
		for (int k = 0; k < N_INT; k++) begin
			if (i_egy_raw.vld && !s.test) begin
				ci[k] = corr_act ? 34'(i_egy_cor.inc[k]) : 34'(i_egy_raw.inc[k]);
			end
			src[k] = ci[k];
		end
		for (int k = 0; k < N_DI; k++) begin
			if (dedge[k] && !s.test) src[N_INT + k] = DI_WT;
		end

		// Summaries combine sources; chaining only to lower indices
		for (int m = 0; m < N_SUM; m++) begin
			for (int k = 0; k < N_SRC; k++) begin
				if (s.scfg[m][SC_ADD + k]) sinc[m] = sinc[m] + src[k];
				if (s.scfg[m][SC_SUB + k]) sinc[m] = sinc[m] - src[k];
			end
			li = int'(s.scfg[m][SC_LIX +: 4]);
			if (s.scfg[m][SC_LEN] && li < m) begin
				if (s.scfg[m][SC_LSUB]) sinc[m] = sinc[m] - sinc[li];
				else sinc[m] = sinc[m] + sinc[li];
			end
			ci[N_INT + m] = sinc[m];
			n.ten[m][s.tariff] = wrapc(s.ten[m][s.tariff], sinc[m], s.roll);
		end

		// Energy counters and per-interval energy of every accumulator
		for (int k = 0; k < N_PW; k++) begin
			n.cnt[k] = wrapc(s.cnt[k], ci[k], s.roll);
			n.pe[k] = s.pe[k] + ci[k][31:0];
			n.ps[k] = s.ps[k] + ci[k][31:0];
		end
		for (int k = 0; k < N_RMS; k++) begin
			if (i_rms.vld) n.rsum[k] = s.rsum[k] + 48'(i_rms.val[k]);
		end
		if (i_rms.vld) n.rcnt = s.rcnt + 16'h0001;

		// Millisecond and second time base
		ms_tick = s.ms_div == 32'(MS_CYC - 1);
		n.ms_div = ms_tick ? 32'h0 : s.ms_div + 32'h1;
		if (ms_tick) begin
			sec_tick = s.ms_cnt == 16'(SEC_MS - 1);
			n.ms_cnt = sec_tick ? 16'h0 : s.ms_cnt + 16'h1;
		end
		pp = 16'(s.pwr_per) * 16'(SEC_PER_MIN);
		if (sec_tick) begin
			n.secs = s.secs + 32'h1;
			n.seq_on = 1'b1;
			n.seq_j = '0;
			n.seq_re = s.rsec + 16'h1 >= s.rms_per;
			n.seq_pe = s.psec + 16'h1 >= pp;
			n.rsec = n.seq_re ? 16'h0 : s.rsec + 16'h1;
			n.psec = n.seq_pe ? 16'h0 : s.psec + 16'h1;
			for (int k = 0; k < N_PW; k++) begin
				n.pl[k] = n.ps[k];
				n.ps[k] = '0;
			end
		end

		// Once a second the walker visits one channel per cycle
		if (s.seq_on) begin
			if (j < N_PW) begin
				ev = s.pe[j][31] ? 32'h0 : s.pe[j];
				lv = s.pl[j][31] ? 32'h0 : s.pl[j];
				hs = hist(s.pwin[j], s.wp, s.win - 4'h1);
				bv = div_w(48'(ev), pp);
				if (s.seq_pe) begin
					n.pblk[j] = bv;
					n.pwin[j][s.wp] = bv;
					n.pe[j] = ci[j][31:0];
					sl = div_w(48'(hs) + 48'(bv), 16'(s.win));
					n.pslid[j] = sl;
					n.pacc[j] = '0;
					n.ppred[j] = (j < N_INT) ? sl : 32'h0;
					if (sl > s.pmax[j]) begin
						n.pmax[j] = sl;
						n.pts[j] = s.secs;
					end
					if (j >= N_INT && sl > s.tmax[j - N_INT][s.tariff]) begin
						n.tmax[j - N_INT][s.tariff] = sl;
						n.tts[j - N_INT][s.tariff] = s.secs;
					end
				end else begin
					n.pacc[j] = bv;
					rem = pp - s.psec;
					pb = div_w(48'(ev) + 48'(lv) * 48'(rem), pp);
					n.ppred[j] = (j < N_INT) ? div_w(48'(hs) + 48'(pb), 16'(s.win)) : 32'h0;
				end
			end
			if (j < N_RMS && s.seq_re) begin
				ri = div_w(s.rsum[j], s.rcnt);
				n.rblk[j] = ri;
				n.rsum[j] = i_rms.vld ? 48'(i_rms.val[j]) : 48'h0;
				if (ri > s.rmax[j]) begin
					n.rmax[j] = ri;
					n.rts[j] = s.secs;
				end
				if (j == N_RMS - 1) n.rcnt = i_rms.vld ? 16'h1 : 16'h0;
			end
			if (j == N_PW - 1) begin
				n.seq_on = 1'b0;
				if (s.seq_pe) n.wp = (s.wp == 4'(WIN_MAX - 1)) ? 4'h0 : s.wp + 4'h1;
			end else begin
				n.seq_j = s.seq_j + 5'h1;
			end
		end

		// Maximum reset wins over a same-cycle update
		if (md_cmd) begin
			n.rmax = '0;
			n.rts = '0;
			n.pmax = '0;
			n.pts = '0;
			n.tmax = '0;
			n.tts = '0;
		end

		// Relay energy pulses from metered import energy
		for (int r = 0; r < N_RLY; r++) begin
			t16 = s.rly_cfg[RC_SRC + r] ? 16'(ci[EI_KVARH_IMP]) : 16'(ci[EI_KWH_IMP]);
			n.racc[r] = s.racc[r] + 32'(t16);
			if (ms_tick && s.rtm[r] != 16'h0) n.rtm[r] = s.rtm[r] - 16'h1;
			if (s.rly_rate != 32'h0 && n.racc[r] >= s.rly_rate) begin
				n.racc[r] = n.racc[r] - s.rly_rate;
				if (s.rly_cfg[RC_KYZ + r]) n.rtog[r] = !s.rtog[r];
				else n.rtm[r] = s.rly_cfg[15:0];
			end
			ovr = s.rly_cfg[RC_KYZ + r] ? n.rtog[r] : (n.rtm[r] != 16'h0);
			n.rly[r] = ovr ^ s.rly_cfg[RC_POL + r];
		end

		// LEDs count uncorrected import energy, test mode included
		for (int l = 0; l < N_LED; l++) begin
			t16 = (l == 0) ? i_egy_raw.inc[EI_KWH_IMP] : i_egy_raw.inc[EI_KVARH_IMP];
			if (i_egy_raw.vld) n.lacc[l] = s.lacc[l] + 32'(t16);
			if (ms_tick && s.ltm[l] != 16'h0) n.ltm[l] = s.ltm[l] - 16'h1;
			if (s.led_k != 32'h0 && n.lacc[l] >= s.led_k) begin
				n.lacc[l] = n.lacc[l] - s.led_k;
				n.ltm[l] = LED_MS;
			end
			n.led[l] = n.ltm[l] != 16'h0;
		end

		n.setpt_en = !n.test;
		n.evrec_en = !n.test;
		n.corr_en = n.corr && !n.test;

		// Register reads, answered in the next cycle
		n.rdata = '0;
		if (i_rd) begin
			unique case (i_addr[11:8])
				RG_CFG: begin
					unique case (ix)
						REG_CTRL: n.rdata = {30'h0, s.corr, s.test};
						REG_RMS_PER: n.rdata = {16'h0, s.rms_per};
						REG_PWR_PER: n.rdata = {24'h0, s.pwr_per};
						REG_WIN: n.rdata = {28'h0, s.win};
						REG_ROLL: n.rdata = s.roll;
						REG_LED_K: n.rdata = s.led_k;
						REG_RLY_RATE: n.rdata = s.rly_rate;
						REG_RLY_CFG: n.rdata = s.rly_cfg;
						REG_TARIFF: n.rdata = {28'h0, s.tariff};
						REG_SECS: n.rdata = s.secs;
						default: n.rdata = '0;
					endcase
				end
				RG_SCFG: if (ix < 8'(N_SUM)) n.rdata = {8'h0, s.scfg[ix[3:0]]};
				RG_RBLK: if (ix < 8'(N_RMS)) n.rdata = s.rblk[ix[2:0]];
				RG_RMAX: if (ix < 8'(N_RMS)) n.rdata = s.rmax[ix[2:0]];
				RG_RTS: if (ix < 8'(N_RMS)) n.rdata = s.rts[ix[2:0]];
				RG_PBLK: if (ix < 8'(N_PW)) n.rdata = s.pblk[ix[4:0]];
				RG_PSLD: if (ix < 8'(N_PW)) n.rdata = s.pslid[ix[4:0]];
				RG_PACC: if (ix < 8'(N_PW)) n.rdata = s.pacc[ix[4:0]];
				RG_PPRD: if (ix < 8'(N_PW)) n.rdata = s.ppred[ix[4:0]];
				RG_PMAX: if (ix < 8'(N_PW)) n.rdata = s.pmax[ix[4:0]];
				RG_PTS: if (ix < 8'(N_PW)) n.rdata = s.pts[ix[4:0]];
				RG_ECNT: if (ix < 8'(N_PW)) n.rdata = s.cnt[ix[4:0]];
				RG_TEN: n.rdata = s.ten[ix[7:4]][ix[3:0]];
				RG_TMAX: n.rdata = s.tmax[ix[7:4]][ix[3:0]];
				RG_TTS: n.rdata = s.tts[ix[7:4]][ix[3:0]];
				default: n.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			s <= '0;
			s.rms_per <= RMS_PER_RST;
			s.pwr_per <= PWR_PER_RST;
			s.win <= WIN_RST;
			s.roll <= ROLL_RST;
			s.led_k <= LED_K_RST;
			s.rly_rate <= RLY_RATE_RST;
			s.rly_cfg <= RLY_CFG_RST;
			s.setpt_en <= 1'b1;
			s.evrec_en <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign o_rdata = s.rdata;
	assign o_relay = s.rly;
	assign o_led = s.led;
	assign o_setpt_en = s.setpt_en;
	assign o_evrec_en = s.evrec_en;
	assign o_corr_en = s.corr_en;

	default clocking dcb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	sequence seq_end_step(int ch);
		s.seq_on && s.seq_pe && s.seq_j == 5'(ch);
	endsequence

	chk_test_quiet: assert property (s.test |-> !o_setpt_en && !o_evrec_en && !o_corr_en)
		else $error("test mode left setpoints, recording or correction on");
	chk_egy_frozen: assert property (s.test |=> s.cnt == $past(s.cnt))
		else $error("energy counters moved in test mode");
	chk_period_range: assert property (s.rms_per >= RMS_PER_MIN && s.rms_per <= RMS_PER_MAX
			&& s.pwr_per >= PWR_PER_MIN && s.pwr_per <= PWR_PER_MAX)
		else $error("demand period out of range");
	chk_win_range: assert property (s.win >= 4'h1 && s.win <= 4'(WIN_MAX))
		else $error("window length out of range");
	chk_win_step: assert property (seq_end_step(N_PW - 1) |=>
			s.wp == (($past(s.wp) == 4'(WIN_MAX - 1)) ? 4'h0 : $past(s.wp) + 4'h1))
		else $error("window did not advance at interval end");
	chk_acc_restart: assert property (seq_end_step(0) |=> s.pacc[0] == 32'h0)
		else $error("accumulated demand not restarted");
	chk_sum_nopred: assert property (s.ppred[N_INT] == 32'h0)
		else $error("summary demand shows a predicted value");
	chk_win1_block: assert property (seq_end_step(0) and s.win == 4'h1 |=>
			s.pslid[0] == s.pblk[0])
		else $error("single-entry window differs from block demand");
	chk_max_above: assert property (seq_end_step(0) and !md_cmd |=>
			s.pmax[0] >= s.pslid[0] && s.pmax[0] >= $past(s.pmax[0]))
		else $error("maximum demand below sliding demand");
	chk_md_clear: assert property (md_cmd |=> s.pmax == '0 && s.pts == '0 && s.rmax == '0)
		else $error("maximum reset left values");
	chk_roll_wrap: assert property ($stable(s.roll) && $past(s.cnt[0]) < $past(s.roll)
			|-> s.cnt[0] < s.roll)
		else $error("energy counter passed roll value");
endmodule // dea_top

// ==== test/dea_core_mdl.sv ====
// Measurement core stand-in: one-second aggregates and energy increments
`timescale 1ns/1ps
module dea_core_mdl #(
	parameter int PER = 40,
	parameter int PHASE = 17
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_go,
	input wire logic i_auto,
	input wire logic [31:0] i_val_a,
	input wire logic [31:0] i_val_b,
	input wire logic [dea_pkg::N_INT-1:0][15:0] i_inc,
	output dea_pkg::dea_rms_t o_rms,
	output dea_pkg::dea_egy_t o_egy_raw,
	output dea_pkg::dea_egy_t o_egy_cor
);
	import dea_pkg::*;
	int cnt;
	logic vld;
	logic sel;
	logic [31:0] cur;
	// Once a second, away from the second tick, or on demand
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt <= 0;
			vld <= 1'b0;
			sel <= 1'b0;
		end else begin
			cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
			vld <= i_go || (i_auto && cnt == PHASE);
			if (vld)
				sel <= ~sel;
		end
	end
	assign cur = sel ? i_val_b : i_val_a;
	// Idle lines carry the inverse so nothing stale looks valid
	always_comb begin
		o_rms.vld = vld;
		o_egy_raw.vld = vld;
		o_egy_cor.vld = vld;
		for (int j = 0; j < N_RMS; j++)
			o_rms.val[j] = vld ? cur : ~cur;
		for (int j = 0; j < N_INT; j++) begin
			o_egy_raw.inc[j] = vld ? i_inc[j] : ~i_inc[j];
			o_egy_cor.inc[j] = vld ? i_inc[j] + 16'h0001 : ~i_inc[j];
		end
	end
endmodule // dea_core_mdl

// ==== test/test_demand_energy_accumulator.sv ====
// Register-level tests of the demand and energy block
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fails++; \
	$display("FAIL %0t got %0h exp %0h", $time, (got), (exp)); end end
module test_demand_energy_accumulator;
	import dea_pkg::*;
	logic clk;
	logic rst;
	logic [11:0] addr;
	logic [31:0] wdata;
	logic wr_s;
	logic rd_s;
	logic [31:0] rdata;
	dea_rms_t rms;
	dea_egy_t egy_raw;
	dea_egy_t egy_cor;
	logic [N_DI-1:0] di;
	logic [N_RLY-1:0] relay;
	logic [N_LED-1:0] led;
	logic setpt;
	logic evrec;
	logic corr;
	logic go;
	logic auto;
	logic [31:0] va;
	logic [31:0] vb;
	logic [N_INT-1:0][15:0] inc;
	logic [31:0] b1;
	logic [31:0] p;
	logic [31:0] d;
	int fails;
	int num_checks;
	int k;
	dea_top #(.MS_CYC(10), .SEC_MS(4)) dut (.i_ref_clk(clk), .i_rst(rst), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_rms(rms),
		.i_egy_raw(egy_raw), .i_egy_cor(egy_cor), .i_di(di), .o_relay(relay), .o_led(led),
		.o_setpt_en(setpt), .o_evrec_en(evrec), .o_corr_en(corr));
	dea_core_mdl #(.PER(40), .PHASE(17)) core (.i_ref_clk(clk), .i_rst(rst), .i_go(go),
		.i_auto(auto), .i_val_a(va), .i_val_b(vb), .i_inc(inc), .o_rms(rms),
		.o_egy_raw(egy_raw), .o_egy_cor(egy_cor));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] g, input logic [7:0] x, input logic [31:0] v);
		@(posedge clk);
		addr <= {g, x};
		wdata <= v;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] g, input logic [7:0] x, output logic [31:0] v);
		@(posedge clk);
		addr <= {g, x};
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		v = rdata;
	endtask
	task automatic rc(input logic [3:0] g, input logic [7:0] x, input logic [31:0] e);
		logic [31:0] v;
		rd(g, x, v);
		`CHK(v, e)
	endtask
	task automatic pulse;
		@(posedge clk);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		#1;
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		rst = 1'b1;
		addr = '0;
		wdata = '0;
		wr_s = 1'b0;
		rd_s = 1'b0;
		di = '0;
		go = 1'b0;
		auto = 1'b0;
		va = 32'h00000064;
		vb = 32'h0000012c;
		inc = '0;
		fails = 0;
		num_checks = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		#1;
		`CHK(relay, 2'b00)
		`CHK({setpt, evrec, corr}, 3'b110)
		rc(RG_CFG, REG_CTRL, 32'h00000000);
		rc(RG_CFG, REG_RMS_PER, 32'(RMS_PER_RST));
		rc(RG_CFG, REG_PWR_PER, 32'(PWR_PER_RST));
		rc(RG_CFG, REG_WIN, 32'(WIN_RST));
		rc(RG_CFG, REG_ROLL, ROLL_RST);
		rc(RG_CFG, REG_LED_K, LED_K_RST);
		rc(RG_CFG, REG_RLY_RATE, RLY_RATE_RST);
		rc(RG_CFG, REG_RLY_CFG, RLY_CFG_RST);
		rc(RG_CFG, 8'hff, 32'h00000000);
		$display("test reset done");
		wr(RG_CFG, REG_WIN, 32'h00000000);
		rc(RG_CFG, REG_WIN, 32'h00000001);
		wr(RG_CFG, REG_WIN, 32'h00000010);
		rc(RG_CFG, REG_WIN, 32'h0000000f);
		wr(RG_CFG, REG_PWR_PER, 32'h00000000);
		rc(RG_CFG, REG_PWR_PER, 32'h00000001);
		wr(RG_CFG, REG_PWR_PER, 32'h0000003d);
		rc(RG_CFG, REG_PWR_PER, 32'h0000003c);
		wr(RG_CFG, REG_RMS_PER, 32'h00000000);
		rc(RG_CFG, REG_RMS_PER, 32'h00000001);
		wr(RG_CFG, REG_RMS_PER, 32'h00002329);
		rc(RG_CFG, REG_RMS_PER, 32'h00002328);
		wr(RG_CFG, REG_CTRL, 32'h00000004);
		rc(RG_CFG, REG_CTRL, 32'h00000000);
		wr(RG_RBLK, 8'h00, 32'h00000055);
		rc(RG_RBLK, 8'h00, 32'h00000000);
		$display("test limits done");
		wr(RG_CFG, REG_CTRL, 32'h00000003);
		cyc(2);
		`CHK({setpt, evrec, corr}, 3'b000)
		@(posedge clk);
		inc <= {16'h0000, 16'h0000, 16'h0064, 16'h0000, 16'h0064};
		pulse();
		for (k = 0; k < 20 && led !== 2'b11; k++)
			cyc(1);
		`CHK(led, 2'b11)
		cyc(80);
		`CHK(led, 2'b11)
		cyc(40);
		`CHK(led, 2'b00)
		rc(RG_ECNT, 8'h00, 32'h00000000);
		wr(RG_CFG, REG_CTRL, 32'h00000000);
		wr(RG_CFG, REG_LED_K, 32'hffffffff);
		$display("test led done");
		wr(RG_CFG, REG_ROLL, 32'h000003e8);
		wr(RG_CFG, REG_RLY_RATE, 32'h0000012c);
		wr(RG_CFG, REG_RLY_CFG, 32'h00060005);
		wr(RG_SCFG, 8'h00, 32'h00000006);
		wr(RG_SCFG, 8'h01, 32'h00000802);
		wr(RG_SCFG, 8'h02, 32'h00040010);
		wr(RG_SCFG, 8'h03, 32'h00000020);
		wr(RG_CFG, REG_TARIFF, 32'h00000003);
		cyc(2);
		`CHK(relay, 2'b01)
		@(posedge clk);
		inc <= {16'h0007, 16'h0000, 16'h0032, 16'h0064, 16'h012c};
		pulse();
		cyc(5);
		`CHK(relay, 2'b10)
		cyc(70);
		`CHK(relay, 2'b11)
		for (k = 0; k < 3; k++) begin
			pulse();
			cyc(80);
		end
		`CHK(relay, 2'b01)
		for (k = 0; k < 3; k++) begin
			@(posedge clk);
			di[0] <= 1'b1;
			cyc(5);
			@(posedge clk);
			di[0] <= 1'b0;
			cyc(5);
		end
		cyc(10);
		rc(RG_ECNT, 8'h00, 32'h000000c8);
		rc(RG_ECNT, 8'h01, 32'h00000190);
		rc(RG_ECNT, 8'h05, 32'h00000258);
		rc(RG_ECNT, 8'h06, 32'h000000c8);
		rc(RG_ECNT, 8'h07, 32'h00000274);
		rc(RG_ECNT, 8'h08, 32'h00000003);
		rc(RG_TEN, 8'h03, 32'h00000258);
		rc(RG_TEN, 8'h00, 32'h00000000);
		wr(RG_CFG, REG_CTRL, 32'h00000002);
		cyc(2);
		`CHK(corr, 1'b1)
		pulse();
		cyc(5);
		rc(RG_ECNT, 8'h01, 32'h000001f5);
		wr(RG_CFG, REG_CTRL, 32'h00000003);
		pulse();
		cyc(5);
		rc(RG_ECNT, 8'h01, 32'h000001f5);
		$display("test energy done");
		wr(RG_CFG, REG_CTRL, 32'h00000000);
		wr(RG_CFG, REG_RMS_PER, 32'h00000002);
		wr(RG_CFG, REG_PWR_PER, 32'h00000001);
		wr(RG_CFG, REG_WIN, 32'h00000001);
		@(posedge clk);
		inc <= {16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h003c};
		auto <= 1'b1;
		cyc(200);
		wr(RG_CFG, REG_CTRL, 32'h00000004);
		rc(RG_RMAX, 8'h00, 32'h00000000);
		rc(RG_RTS, 8'h00, 32'h00000000);
		cyc(240);
		for (int j = 0; j < N_RMS; j++)
			rc(RG_RBLK, 8'(j), 32'h000000c8);
		rc(RG_RMAX, 8'h00, 32'h000000c8);
		$display("test volt demand done");
		cyc(7600);
		rd(RG_PBLK, 8'h00, b1);
		`CHK(b1, 32'h0000003c)
		rc(RG_PSLD, 8'h00, b1);
		rc(RG_PPRD, 8'h00, b1);
		rc(RG_PPRD, 8'h05, 32'h00000000);
		rd(RG_PACC, 8'h00, d);
		`CHK(d <= b1, 1'b1)
		wr(RG_CFG, REG_WIN, 32'h00000002);
		@(posedge clk);
		inc[0] <= 16'h0078;
		p = b1;
		for (k = 0; k < 150; k++) begin
			rd(RG_PBLK, 8'h00, d);
			if (d === 2 * b1)
				break;
			p = d;
			cyc(40);
		end
		`CHK(d, 2 * b1)
		rc(RG_PSLD, 8'h00, (p + 2 * b1) / 2);
		rc(RG_PMAX, 8'h00, (p + 2 * b1) / 2);
		$display("test power demand done");
		conclude();
	end
endmodule // test_demand_energy_accumulator
